// >>> core/csi2_packet_assembler_consts.vh
// Constants for the CSI-2 packet assembler: register offsets, fields and encodings
`ifndef CSI2_PACKET_ASSEMBLER_CONSTS_VH
`define CSI2_PACKET_ASSEMBLER_CONSTS_VH
`define REG_TX_LANE_RATE_CTL     8'h1f
`define REG_FORWARD_CONTROL_ONE  8'h20
`define REG_TX_LINK_STATUS       8'h35
`define REG_TEN_BIT_CHANNEL_TYPE 8'h70
`define REG_TWELVE_BIT_CHAN_TYPE 8'h71
`define REG_PORT_CHANNEL_REMAP   8'h72
`define REG_PORT_CONFIG_SECOND   8'h7c
`define REG_TIMING_OVERRIDE      8'h7d
`define RST_LANE_RATE            8'h00
`define RST_FORWARD              8'h00
`define RST_CHANNEL_TYPE         8'h2b
`define RST_TWELVE_TYPE          8'h2c
`define RST_REMAP                8'he4
`define RST_PORT_CONFIG          8'h00
`define RATE_HIGH                2'b00
`define RATE_RESERVED            2'b01
`define RATE_800                 2'b10
`define RATE_400                 2'b11
`define DT_FRAME_START           6'h00
`define DT_FRAME_END             6'h01
`define DT_LINE_START            6'h02
`define DT_LINE_END              6'h03
`define DT_SHORT_MAX             6'h0f
`define CRC_SEED                 16'hffff
`define CRC_POLY_REFLECTED       16'h8408
`define PIXEL_WIDTH              12
`define LINE_BUFFER_BYTES        16384
`define PASS_BIT                 0
`define SYNC_BIT                 1
`endif

// >>> core/csi2_header_ecc.v
// Header error code generator over data identifier and word count
`timescale 1ns/10ps
module csi2_header_ecc (
  input  wire [23:0] header_bits,
  output wire [7:0]  ecc
);
  wire [23:0] d = header_bits;
  // Hamming-modified code, single correct and double detect at the receiver
  assign ecc[0] = d[0]^d[1]^d[2]^d[4]^d[5]^d[7]^d[10]^d[11]^d[13]^d[16]^d[20]^d[21]
                  ^d[22]^d[23];
  assign ecc[1] = d[0]^d[1]^d[3]^d[4]^d[6]^d[8]^d[10]^d[12]^d[14]^d[17]^d[20]^d[21]
                  ^d[22]^d[23];
  assign ecc[2] = d[0]^d[2]^d[3]^d[5]^d[6]^d[9]^d[11]^d[12]^d[15]^d[18]^d[20]^d[21]
                  ^d[22];
  assign ecc[3] = d[1]^d[2]^d[3]^d[7]^d[8]^d[9]^d[13]^d[14]^d[15]^d[19]^d[20]^d[21]
                  ^d[23];
  assign ecc[4] = d[4]^d[5]^d[6]^d[7]^d[8]^d[9]^d[16]^d[17]^d[18]^d[19]^d[20]^d[22]
                  ^d[23];
  assign ecc[5] = d[10]^d[11]^d[12]^d[13]^d[14]^d[15]^d[16]^d[17]^d[18]^d[19]^d[21]
                  ^d[22]^d[23];
  assign ecc[6] = 1'b0;
  assign ecc[7] = 1'b0;
endmodule

// >>> core/csi2_skid_buffer.v
// Two-entry valid/ready buffer on the outbound byte path
`timescale 1ns/10ps
module csi2_skid_buffer #(
  parameter WIDTH = 9
) (
  input  wire             ref_clk,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] slot [0:1];
  reg             wr_ptr;
  reg             rd_ptr;
  reg [1:0]       count;
  wire            push = in_valid && (count != 2'd2);
  wire            pop  = out_ready && (count != 2'd0);
  assign in_ready  = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data  = slot[rd_ptr];
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end else begin
      if (push) begin
        slot[wr_ptr] <= in_data;
        wr_ptr       <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// >>> core/csi2_packet_assembler.v
// CSI-2 packet assembler: line buffers, packet framing, register file and status
// Function
// - Short sync packets use data types 0x00 to 0x0F only.
// - Long packet is 32-bit header, byte payload, then 16-bit footer.
// - Header order: data identifier, 16-bit word count, 8-bit ECC.
// - Word count equals number of payload bytes.
// - ECC covers identifier and word count; corrects one, detects two bits.
// - Footer carries 16-bit CRC over the payload.
// - Payload bytes pass through unchanged, any value allowed.
// - Virtual channel sits in the top two identifier bits.
// - Data type sits in the low six identifier bits.
// - Frame and line boundaries come from vsync and hsync inputs.
// - Accept 8, 10 and 12 bit raw pixel formats.
// - Per-port bytes for 10 and 12 bit modes hold channel and type.
// - 8-bit video runs in 10-bit mode; config selects upper or lower byte.
// - Each port remaps independently to any of four channels.
// - Transmitter interleaves up to four channels on one link.
// - Two-bit lane rate field selects 1.6G, reserved, 800M, 400M.
// - Timing auto at 800M and 1.6G; 400M needs software override.
// - Pass flag set while valid data flows, cleared when idle or on error.
// - Sync flag reads zero while synchronized forwarding is off.
// - Status changes can raise an event and drive a status pin.
// - One line buffer per port, four, 16 kB each.
// - Do not pull a packet until it is fully in the buffer.
// - Forwarding disabled after reset until software enables each port.
// - Each buffer goes to at most one transmitter; engines independent.
`timescale 1ns/10ps
`include "csi2_packet_assembler_consts.vh"
module csi2_packet_assembler #(
  parameter PORTS     = 4,
  parameter BUF_BYTES = `LINE_BUFFER_BYTES,
  parameter ADDR_W    = 14
) (
  input  wire                      ref_clk,
  input  wire                      reset_n,
  input  wire [PORTS-1:0]          pix_clk,
  input  wire [PORTS-1:0]          pix_vsync,
  input  wire [PORTS-1:0]          pix_hsync,
  input  wire [PORTS*`PIXEL_WIDTH-1:0] pix_data,
  input  wire [PORTS-1:0]          pix_err,
  input  wire [1:0]                port_sel,
  input  wire                      reg_wr,
  input  wire [7:0]                reg_addr,
  input  wire [7:0]                reg_wdata,
  output reg  [7:0]                reg_rdata,
  output reg  [7:0]                tx_byte,
  output reg                       tx_valid,
  output reg                       tx_last,
  input  wire                      tx_ready,
  output reg  [1:0]                tx_rate,
  output reg                       tx_timing_auto,
  output reg                       tx_status_pin,
  output reg                       tx_status_event
);
  localparam S_IDLE = 3'd0;
  localparam S_HDR  = 3'd1;
  localparam S_PAY  = 3'd2;
  localparam S_FTR  = 3'd3;
  localparam S_NEXT = 3'd4;

  function [15:0] crc_byte;
    input [15:0] crc;
    input [7:0]  data;
    integer i;
    reg [15:0] c;
    begin
      c = crc;
      for (i = 0; i < 8; i = i + 1)
        c = (c[0] ^ data[i]) ? ((c >> 1) ^ `CRC_POLY_REFLECTED) : (c >> 1);
      crc_byte = c;
    end
  endfunction

  function [7:0] pixel_byte;
    input [11:0] pix;
    input        twelve;
    input        low_sel;
    begin
      if (twelve)
        pixel_byte = pix[11:4];
      else if (low_sel)
        pixel_byte = pix[7:0];
      else
        pixel_byte = pix[9:2];
    end
  endfunction

  // Registers; per-port bytes selected by port_sel
  reg [7:0] lane_rate_ctl;
  reg [7:0] forward_control_one;
  reg [7:0] timing_override;
  reg [7:0] ten_type   [0:PORTS-1];
  reg [7:0] twelve_type[0:PORTS-1];
  reg [7:0] port_cfg   [0:PORTS-1];
  reg [7:0] port_channel_remap;
  reg [7:0] tx_link_status;

  // Input synchronisers, two flip-flops per pin, three on pix_clk for edge detection
  reg [PORTS-1:0] clk_s1, clk_s2, clk_s3;
  reg [PORTS-1:0] vs_s1, vs_s2, hs_s1, hs_s2, err_s1, err_s2;
  reg [PORTS*`PIXEL_WIDTH-1:0] dat_s1, dat_s2;
  always @(posedge ref_clk) begin
    clk_s1 <= pix_clk;
    clk_s2 <= clk_s1;
    clk_s3 <= clk_s2;
    vs_s1  <= pix_vsync;
    vs_s2  <= vs_s1;
    hs_s1  <= pix_hsync;
    hs_s2  <= hs_s1;
    err_s1 <= pix_err;
    err_s2 <= err_s1;
    dat_s1 <= pix_data;
    dat_s2 <= dat_s1;
  end
  wire [PORTS-1:0] pix_rise = clk_s2 & ~clk_s3;
  // A port owned by the other transmitter queues nothing here, so no stale packet waits
  wire [PORTS-1:0] fwd_on = forward_control_one[PORTS-1:0] & ~forward_control_one[7:4];

  // Per-port line capture; one buffer per port, 16 kB each
  reg [7:0]        line_mem [0:PORTS*BUF_BYTES-1];
  reg [ADDR_W-1:0] wr_cnt [0:PORTS-1];
  reg [15:0]       line_len [0:PORTS-1];
  reg [PORTS-1:0]  hs_prev, vs_prev;
  reg [PORTS-1:0]  line_ready, fs_pend, fe_pend, line_err;
  reg [PORTS-1:0]  done_line, done_fs, done_fe;
  integer p;
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      hs_prev    <= {PORTS{1'b0}};
      vs_prev    <= {PORTS{1'b0}};
      line_ready <= {PORTS{1'b0}};
      fs_pend    <= {PORTS{1'b0}};
      fe_pend    <= {PORTS{1'b0}};
      line_err   <= {PORTS{1'b0}};
      for (p = 0; p < PORTS; p = p + 1) begin
        wr_cnt[p]   <= {ADDR_W{1'b0}};
        line_len[p] <= 16'h0000;
      end
    end else begin
      for (p = 0; p < PORTS; p = p + 1) begin
        if (done_line[p])
          line_ready[p] <= 1'b0;
        if (done_fs[p])
          fs_pend[p] <= 1'b0;
        if (done_fe[p])
          fe_pend[p] <= 1'b0;
        if (pix_rise[p]) begin
          hs_prev[p] <= hs_s2[p];
          vs_prev[p] <= vs_s2[p];
          if (vs_s2[p] && !vs_prev[p] && fwd_on[p])
            fs_pend[p] <= 1'b1;
          if (!vs_s2[p] && vs_prev[p] && fwd_on[p])
            fe_pend[p] <= 1'b1;
          if (hs_s2[p] && vs_s2[p] && !line_ready[p]) begin
            line_mem[p*BUF_BYTES + wr_cnt[p]] <= pixel_byte(dat_s2[p*12 +: 12],
              port_cfg[p][5], port_cfg[p][6]);
            wr_cnt[p] <= wr_cnt[p] + 1'b1;
            // Error mark belongs to the line being captured; restart it on the first byte
            line_err[p] <= ((wr_cnt[p] != {ADDR_W{1'b0}}) && line_err[p]) || err_s2[p];
          end
          if (!hs_s2[p] && hs_prev[p]) begin
            // Line complete: only now may it be pulled
            line_len[p] <= {{(16-ADDR_W){1'b0}}, wr_cnt[p]};
            line_ready[p] <= fwd_on[p] && (wr_cnt[p] != {ADDR_W{1'b0}});
            wr_cnt[p] <= {ADDR_W{1'b0}};
          end
        end
      end
    end
  end

  // Forwarding engine; buffer ownership by map bits keeps engines apart
  wire [PORTS-1:0] owned = ~forward_control_one[7:4];
  reg  [2:0]  state;
  reg  [1:0]  cur_port;
  reg  [1:0]  rr_port;
  reg         cur_long;
  reg  [31:0] header;
  reg  [1:0]  hdr_idx;
  reg  [15:0] pay_idx;
  reg  [15:0] crc;
  reg         ftr_idx;
  reg  [7:0]  buf_byte;
  reg         buf_vld;
  reg         buf_last;
  wire        buf_rdy;
  wire [8:0]  out_word;
  wire        out_vld;
  wire [23:0] ecc_in;
  wire [7:0]  ecc_out;
  reg  [5:0]  sel_dt;
  reg  [1:0]  sel_vc;
  reg  [15:0] sel_wc;
  reg         sel_long;
  reg         sel_any;
  reg  [1:0]  sel_port;
  reg  [1:0]  cand;
  integer k;

  always @* begin
    sel_any  = 1'b0;
    sel_port = rr_port;
    sel_long = 1'b0;
    sel_dt   = `DT_FRAME_START;
    cand     = 2'd0;
    for (k = PORTS - 1; k >= 0; k = k - 1) begin
      cand = rr_port + k[1:0]; // Round robin across ports
      if ((fs_pend[cand] || fe_pend[cand] || line_ready[cand]) && owned[cand]) begin
        sel_any  = 1'b1;
        sel_port = cand;
      end
    end
    if (fs_pend[sel_port])
      sel_dt = `DT_FRAME_START;
    else if (line_ready[sel_port]) begin
      sel_long = 1'b1;
      sel_dt   = port_cfg[sel_port][5] ? twelve_type[sel_port][5:0]
                                       : ten_type[sel_port][5:0];
    end else
      sel_dt = `DT_FRAME_END;
    sel_vc = port_channel_remap[sel_port*2 +: 2];
    sel_wc = sel_long ? line_len[sel_port] : 16'h0000;
  end

  assign ecc_in = {sel_wc, sel_vc, sel_dt};
  csi2_header_ecc u_ecc (
    .header_bits (ecc_in),
    .ecc         (ecc_out)
  );

  always @* begin
    done_line = {PORTS{1'b0}};
    done_fs   = {PORTS{1'b0}};
    done_fe   = {PORTS{1'b0}};
    if (state == S_IDLE && sel_any) begin
      if (fs_pend[sel_port])
        done_fs[sel_port] = 1'b1;
      else if (!line_ready[sel_port])
        done_fe[sel_port] = 1'b1;
    end
    if (state == S_NEXT && cur_long)
      done_line[cur_port] = 1'b1;
  end

  always @(posedge ref_clk) begin
    if (!reset_n) begin
      state    <= S_IDLE;
      cur_port <= 2'd0;
      rr_port  <= 2'd0;
      cur_long <= 1'b0;
      header   <= 32'h00000000;
      hdr_idx  <= 2'd0;
      pay_idx  <= 16'h0000;
      crc      <= `CRC_SEED;
      ftr_idx  <= 1'b0;
      buf_byte <= 8'h00;
      buf_vld  <= 1'b0;
      buf_last <= 1'b0;
    end else begin
      if (buf_vld && buf_rdy)
        buf_vld <= 1'b0;
      case (state)
        S_IDLE: begin
          if (sel_any) begin
            cur_port <= sel_port;
            cur_long <= sel_long;
            header   <= {ecc_out, sel_wc, sel_vc, sel_dt};
            hdr_idx  <= 2'd0;
            pay_idx  <= 16'h0000;
            crc      <= `CRC_SEED;
            ftr_idx  <= 1'b0;
            state    <= S_HDR;
          end
        end
        S_HDR: begin
          if (!buf_vld || buf_rdy) begin
            buf_byte <= header[hdr_idx*8 +: 8];
            buf_vld  <= 1'b1;
            buf_last <= (hdr_idx == 2'd3) && !cur_long;
            hdr_idx  <= hdr_idx + 2'd1;
            if (hdr_idx == 2'd3)
              state <= cur_long ? S_PAY : S_NEXT;
          end
        end
        S_PAY: begin
          if (!buf_vld || buf_rdy) begin
            buf_byte <= line_mem[cur_port*BUF_BYTES + pay_idx[ADDR_W-1:0]];
            crc      <= crc_byte(crc, line_mem[cur_port*BUF_BYTES + pay_idx[ADDR_W-1:0]]);
            buf_vld  <= 1'b1;
            buf_last <= 1'b0;
            pay_idx  <= pay_idx + 16'h0001;
            if (pay_idx + 16'h0001 == header[23:8])
              state <= S_FTR;
          end
        end
        S_FTR: begin
          if (!buf_vld || buf_rdy) begin
            buf_byte <= ftr_idx ? crc[15:8] : crc[7:0];
            buf_vld  <= 1'b1;
            buf_last <= ftr_idx;
            ftr_idx  <= 1'b1;
            if (ftr_idx)
              state <= S_NEXT;
          end
        end
        S_NEXT: begin
          rr_port <= cur_port + 2'd1;
          state   <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // Two-entry buffer so a stall downstream loses no byte
  csi2_skid_buffer #(
    .WIDTH (9)
  ) u_skid (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_data   ({buf_last, buf_byte}),
    .in_valid  (buf_vld),
    .in_ready  (buf_rdy),
    .out_data  (out_word),
    .out_valid (out_vld),
    .out_ready (tx_ready)
  );

  // Register writes
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      lane_rate_ctl       <= `RST_LANE_RATE;
      forward_control_one <= `RST_FORWARD;
      timing_override     <= 8'h00;
      port_channel_remap  <= `RST_REMAP;
      for (p = 0; p < PORTS; p = p + 1) begin
        ten_type[p]    <= `RST_CHANNEL_TYPE;
        twelve_type[p] <= `RST_TWELVE_TYPE;
        port_cfg[p]    <= `RST_PORT_CONFIG;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        `REG_TX_LANE_RATE_CTL:     lane_rate_ctl <= reg_wdata;
        `REG_FORWARD_CONTROL_ONE:  forward_control_one <= reg_wdata;
        `REG_TIMING_OVERRIDE:      timing_override <= reg_wdata;
        `REG_PORT_CHANNEL_REMAP:   port_channel_remap <= reg_wdata;
        `REG_TEN_BIT_CHANNEL_TYPE: ten_type[port_sel] <= reg_wdata;
        `REG_TWELVE_BIT_CHAN_TYPE: twelve_type[port_sel] <= reg_wdata;
        `REG_PORT_CONFIG_SECOND:   port_cfg[port_sel] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Status, outputs and read data
  wire pass_now = out_vld && !(|err_s2) && !(|(line_err & line_ready));
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      tx_link_status  <= 8'h00;
      reg_rdata       <= 8'h00;
      tx_byte         <= 8'h00;
      tx_valid        <= 1'b0;
      tx_last         <= 1'b0;
      tx_rate         <= `RATE_HIGH;
      tx_timing_auto  <= 1'b1;
      tx_status_pin   <= 1'b0;
      tx_status_event <= 1'b0;
    end else begin
      tx_link_status  <= {6'h00, 1'b0, pass_now};
      tx_status_event <= (tx_link_status[`PASS_BIT] != pass_now);
      tx_status_pin   <= tx_link_status[`PASS_BIT];
      tx_byte         <= out_word[7:0];
      // One pulse per byte the receiver took, so a stall never repeats a byte
      tx_valid        <= out_vld && tx_ready;
      tx_last         <= out_word[8] && out_vld && tx_ready;
      tx_rate         <= lane_rate_ctl[1:0];
      tx_timing_auto  <= (lane_rate_ctl[1:0] != `RATE_400) || !timing_override[0];
      case (reg_addr)
        `REG_TX_LANE_RATE_CTL:     reg_rdata <= lane_rate_ctl;
        `REG_FORWARD_CONTROL_ONE:  reg_rdata <= forward_control_one;
        `REG_TX_LINK_STATUS:       reg_rdata <= tx_link_status;
        `REG_TIMING_OVERRIDE:      reg_rdata <= timing_override;
        `REG_PORT_CHANNEL_REMAP:   reg_rdata <= port_channel_remap;
        `REG_TEN_BIT_CHANNEL_TYPE: reg_rdata <= ten_type[port_sel];
        `REG_TWELVE_BIT_CHAN_TYPE: reg_rdata <= twelve_type[port_sel];
        `REG_PORT_CONFIG_SECOND:   reg_rdata <= port_cfg[port_sel];
        default:                   reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule

// >>> bench/csi2_packet_assembler_props.sv
// Checker for the packet assembler's register and byte-stream ports
`timescale 1ns/10ps
module csi2_packet_assembler_props #(
  parameter PORTS = 4
) (
  input wire             ref_clk,
  input wire             reset_n,
  input wire [PORTS-1:0] pix_err,
  input wire             reg_wr,
  input wire [7:0]       reg_addr,
  input wire [7:0]       reg_rdata,
  input wire [7:0]       tx_byte,
  input wire             tx_valid,
  input wire             tx_last,
  input wire             tx_ready,
  input wire [1:0]       tx_rate,
  input wire             tx_timing_auto,
  input wire             tx_status_pin,
  input wire             tx_status_event
);
  logic [15:0] pos;
  logic [7:0]  di;
  logic [15:0] wc;

  // Byte position inside the current packet, with the header fields it has shown
  always @(posedge ref_clk) begin
    if (!reset_n) begin
      pos <= 16'h0000;
      di  <= 8'h00;
      wc  <= 16'h0000;
    end else if (tx_valid) begin
      pos <= tx_last ? 16'h0000 : pos + 16'h0001;
      if (pos == 16'h0000) di <= tx_byte;
      if (pos == 16'h0001) wc[7:0] <= tx_byte;
      if (pos == 16'h0002) wc[15:8] <= tx_byte;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  short_type_a: assert property (tx_valid && tx_last && pos == 16'h0003
    |-> di[5:0] <= 6'h0f) else $error("short packet type above sync range");
  long_count_a: assert property (tx_valid && tx_last && pos > 16'h0003
    |-> pos == wc + 16'h0005) else $error("long packet length differs from word count");
  last_in_byte_a: assert property (tx_last |-> tx_valid)
    else $error("packet end marked without a byte");
  byte_after_ready_a: assert property (tx_valid |-> $past(tx_ready))
    else $error("byte shown without a prior ready");
  sync_reads_zero_a: assert property ($past(reg_addr) == 8'h35 |-> !reg_rdata[1])
    else $error("sync flag read as set");
  auto_timing_a: assert property (!tx_timing_auto |-> tx_rate == 2'b11)
    else $error("manual timing outside the lowest rate");
  rate_field_a: assert property ($past(reg_addr) == 8'h1f && !$past(reg_wr)
    && !$past(reg_wr, 2) && !$past(reg_wr, 3) |-> reg_rdata[1:0] == tx_rate)
    else $error("lane rate output differs from its field");
  status_event_a: assert property (tx_status_pin != $past(tx_status_pin)
    |-> $past(tx_status_event)) else $error("status change without event");
  error_drops_pass_a: assert property ((|pix_err)[*8] |-> ##[0:8] !tx_status_pin)
    else $error("pass flag held during video error");
endmodule

bind csi2_packet_assembler csi2_packet_assembler_props #(.PORTS(PORTS)) props_u (.*);

// >>> bench/csi2_rx_model.sv
// Downstream receiver model: collects the outbound byte stream with its end marks
`timescale 1ns/10ps
module csi2_rx_model (
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire [7:0] tx_byte,
  input  wire       tx_valid,
  input  wire       tx_last,
  input  wire       slow,
  output logic      tx_ready
);
  logic [8:0] got[$];
  logic [1:0] beat = 2'b00;

  initial tx_ready = 1'b0;
  // Slow mode accepts two beats in four, so the skid buffer has to hold words back
  always @(posedge ref_clk) begin
    if (reset_n && tx_valid) got.push_back({tx_last, tx_byte});
    beat <= beat + 2'b01;
    tx_ready <= #1 reset_n && (!slow || beat[1]);
  end
endmodule

// >>> bench/tb.sv
// Self-checking testbench for the CSI-2 packet assembler
`timescale 1ns/10ps
`include "csi2_packet_assembler_consts.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
  localparam logic [15:0] NPIX = 16'h0005;
  logic        ref_clk   = 1'b0;
  logic        reset_n   = 1'b0;
  logic [3:0]  pix_clk   = 4'h0;
  logic [3:0]  pix_vsync = 4'h0;
  logic [3:0]  pix_hsync = 4'h0;
  logic [3:0]  pix_err   = 4'h0;
  logic [47:0] pix_data  = 48'h0;
  logic [1:0]  port_sel  = 2'b00;
  logic        reg_wr    = 1'b0;
  logic [7:0]  reg_addr  = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic        slow      = 1'b0;
  logic        tx_ready;
  wire  [7:0]  reg_rdata;
  wire  [7:0]  tx_byte;
  wire         tx_valid;
  wire         tx_last;
  wire  [1:0]  tx_rate;
  wire         tx_timing_auto;
  wire         tx_status_pin;
  wire         tx_status_event;
  logic [63:0] ra  = 64'h1f_20_35_70_71_72_7c_00;
  logic [63:0] rv  = 64'h00_00_00_2b_2c_e4_00_00;
  logic [5:0]  rates = 6'b11_10_00;
  logic [17:0] dts = {6'h12, 6'h3f, 6'h2b};
  logic [23:0] cfg = {8'h20, 8'h40, 8'h00};
  logic [5:0]  vcs = {2'd0, 2'd2, 2'd0};
  int          fails = 0;
  int          n_compared = 0;

  csi2_packet_assembler #(.BUF_BYTES(1024), .ADDR_W(10)) dut_u (.*);
  csi2_rx_model rx_u (.*);

  initial forever #4 ref_clk = ~ref_clk;
  // Pixel clock offset so its edges stay a fixed 1 ns before a core clock edge
  initial begin
    #3;
    forever #32 pix_clk = ~pix_clk;
  end

  function automatic [7:0] ecc(input [23:0] d);
    ecc = {2'b00, ^(d & 24'heffc00), ^(d & 24'hdf03f0), ^(d & 24'hb8e38e),
           ^(d & 24'h749a6d), ^(d & 24'hf2555b), ^(d & 24'hf12cb7)};
  endfunction

  function automatic [15:0] crc_step(input [15:0] c, input [7:0] d);
    for (int i = 0; i < 8; i++) c = (c[0] ^ d[i]) ? (c >> 1) ^ `CRC_POLY_REFLECTED : c >> 1;
    return c;
  endfunction

  // All-ones and all-zeros pixels so no byte value is treated specially
  function automatic [11:0] pixval(input int i);
    pixval = i == 1 ? 12'hfff : 12'(i * 1741);
  endfunction

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic done(input string s);
    $display("test %s finished, %0d mismatches so far", s, fails);
  endtask

  task automatic wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1 reg_wr = 1'b0;
  endtask

  task automatic rd(input [7:0] a, input [7:0] e);
    @(posedge ref_clk);
    #1 reg_addr = a;
    @(posedge ref_clk);
    #1 `CHK("reg_rdata", e, reg_rdata)
  endtask

  task automatic take(output logic [8:0] b);
    int k;
    for (k = 0; k < 4000 && rx_u.got.size() == 0; k++) @(posedge ref_clk);
    if (rx_u.got.size() == 0) begin
      fails++;
      $display("ERROR stream byte expected within 4000 cycles seen none");
      results();
    end
    b = rx_u.got.pop_front();
  endtask

  task automatic frame(input logic err);
    int i;
    @(negedge pix_clk[0]);
    pix_vsync[0] = 1'b1;
    pix_err[0] = err;
    repeat (4) @(negedge pix_clk[0]);
    for (i = 0; i < NPIX; i++) begin
      pix_hsync[0] = 1'b1;
      pix_data[11:0] = pixval(i);
      @(negedge pix_clk[0]);
    end
    pix_hsync[0] = 1'b0;
    repeat (4) @(negedge pix_clk[0]);
    pix_vsync[0] = 1'b0;
    pix_err[0] = 1'b0;
    repeat (4) @(negedge pix_clk[0]);
  endtask

  task automatic check_short(input [5:0] dt, input [1:0] vc);
    logic [8:0] h[4];
    for (int i = 0; i < 4; i++) take(h[i]);
    `CHK("short_id", {vc, dt}, h[0][7:0])
    `CHK("short_ecc", ecc({h[2][7:0], h[1][7:0], h[0][7:0]}), h[3][7:0])
    `CHK("short_end", 4'b0001, {h[0][8], h[1][8], h[2][8], h[3][8]})
  endtask

  task automatic check_long(input [5:0] dt, input [1:0] vc, input int mode);
    logic [8:0]  h[4];
    logic [8:0]  b;
    logic [11:0] px;
    logic [7:0]  e;
    logic [15:0] c;
    int          i;
    for (i = 0; i < 4; i++) take(h[i]);
    `CHK("data_id", {vc, dt}, h[0][7:0])
    `CHK("word_count", NPIX, {h[2][7:0], h[1][7:0]})
    `CHK("header_ecc", ecc({h[2][7:0], h[1][7:0], h[0][7:0]}), h[3][7:0])
    c = `CRC_SEED;
    for (i = 0; i < NPIX; i++) begin
      take(b);
      px = pixval(i);
      e = mode == 2 ? px[11:4] : (mode == 1 ? px[7:0] : px[9:2]);
      `CHK("payload", {1'b0, e}, b)
      c = crc_step(c, e);
    end
    take(b);
    `CHK("crc_low", c[7:0], b[7:0])
    take(b);
    `CHK("crc_high_last", {1'b1, c[15:8]}, b)
  endtask

  initial begin
    int i;
    int m;
    repeat (16) @(posedge ref_clk);
    #1 reset_n = 1'b1;
    `CHK("timing_auto", 1'b1, tx_timing_auto)
    for (i = 0; i < 8; i++) rd(ra[i*8+:8], rv[i*8+:8]);
    done("reset values");
    for (i = 0; i < 3; i++) begin
      wr(8'h1f, {6'h00, rates[i*2+:2]});
      rd(8'h1f, {6'h00, rates[i*2+:2]});
      `CHK("tx_rate", rates[i*2+:2], tx_rate)
      `CHK("timing_auto", 1'b1, tx_timing_auto)
    end
    wr(8'h7d, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1 `CHK("timing_auto", 1'b0, tx_timing_auto)
    wr(8'h1f, 8'h02);
    rd(8'h1f, 8'h02);
    `CHK("timing_auto", 1'b1, tx_timing_auto)
    wr(8'h7d, 8'h00);
    done("lane rate");
    for (i = 0; i < 2; i++) begin
      wr(8'h20, i ? 8'h11 : 8'h00);
      frame(1'b0);
      repeat (300) @(posedge ref_clk);
      #1 `CHK("bytes_sent", 0, rx_u.got.size())
    end
    done("forwarding off");
    wr(8'h20, 8'h01);
    for (m = 0; m < 3; m++) begin
      slow = m[0];
      wr(m == 2 ? 8'h71 : 8'h70, {2'b00, dts[m*6+:6]});
      wr(8'h7c, cfg[m*8+:8]);
      wr(8'h72, m == 1 ? 8'he6 : 8'he4);
      frame(1'b0);
      check_short(`DT_FRAME_START, vcs[m*2+:2]);
      check_long(dts[m*6+:6], vcs[m*2+:2], m);
      check_short(`DT_FRAME_END, vcs[m*2+:2]);
      done("video mode");
    end
    port_sel = 2'd1;
    wr(8'h7c, 8'h40);
    rd(8'h7c, 8'h40);
    port_sel = 2'd0;
    rd(8'h7c, 8'h20);
    done("per-port config");
    frame(1'b1);
    repeat (400) @(posedge ref_clk);
    rx_u.got.delete();
    rd(8'h35, 8'h00);
    done("error and idle status");
    results();
  end
endmodule
